/* File: logic/tcc_pkg.sv */
/*
 * shared constants of the 16-bit timer capture/compare A block:
 * register offsets, field positions, reset values and mode codes.
 * assumes a plain register port with word-wide registers.
 */
package tcc_pkg;
  // ==========================================================
  // widths
  localparam int CNT_W = 16;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  // ==========================================================
  // register offsets (word index on the plain port)
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_COUNT = 4'h1;
  localparam logic [3:0] OFF_CCA = 4'h2;
  localparam logic [3:0] OFF_STATUS = 4'h3;
  localparam logic [3:0] OFF_MASK = 4'h4;
  // ==========================================================
  // control fields
  localparam int CTRL_RUN = 0;
  localparam int CTRL_MODE_LO = 1;
  localparam int CTRL_MODE_W = 2;
  localparam int CTRL_CAP_A = 3;
  localparam int CTRL_PIN_OUT = 4;
  localparam int CTRL_EDGE_A_RISE = 5;
  localparam int CTRL_EDGE_B_RISE = 6;
  localparam int CTRL_W = 7;
  // ==========================================================
  // status / mask fields
  localparam int ST_MATCH_A = 0;
  localparam int ST_OVF = 1;
  localparam int ST_CAP_A = 2;
  localparam int ST_W = 3;
  // ==========================================================
  // reset values and counter constants
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CCA_RST = 16'h0000;
  localparam logic [6:0] CTRL_RST = 7'h00;
  localparam logic [2:0] ST_RST = 3'h0;
  // ==========================================================
  // counting modes
  typedef enum logic [1:0] {
    TCC_FREE_RUN = 2'h0,
    TCC_CLR_MATCH = 2'h1,
    TCC_CLR_EDGE_A = 2'h2,
    TCC_STOPPED = 2'h3
  } tcc_mode_t;
endpackage : tcc_pkg

/* File: logic/tcc_edge_sync.sv */
/*
 * pin synchroniser with edge detection: three flops, a change counts
 * once the second and third flops agree on a new level.
 * assumes the pin is asynchronous to i_core_clk.
 */
`timescale 1ns/1ps
module tcc_edge_sync (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // pin and edge select
  input wire logic i_pin,
  input wire logic i_rise,
  // detected valid edge
  output logic o_edge
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic lvl_r;

  // ==========================================================
  // synchroniser chain
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= i_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // accepted level follows when stages two and three agree
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      lvl_r <= 1'b0;
    end else if (s2_r == s3_r) begin
      lvl_r <= s3_r;
    end
  end

  // edge of the chosen polarity
  assign o_edge = (s2_r == s3_r) && (s3_r != lvl_r) && (s3_r == i_rise);
endmodule : tcc_edge_sync

/* File: logic/tcc_timer_a.sv */
/*
 * 16-bit timer counter with capture/compare register a.
 * assumes a plain register port: one-cycle strobes, read data in the
 * cycle after the read strobe; pins are asynchronous to the clock.
 */
`timescale 1ns/1ps
module tcc_timer_a #(
  parameter int CNT_W = tcc_pkg::CNT_W
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // register port
  input wire logic [tcc_pkg::ADDR_W-1:0] i_addr,
  input wire logic [tcc_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [tcc_pkg::DATA_W-1:0] o_rdata,
  // pins
  input wire logic i_edge_input_a,
  input wire logic i_shared_port_pin,
  output logic o_shared_port_pin,
  output logic o_shared_port_pin_oe,
  // interrupt and event outputs
  output logic o_irq,
  output logic o_match_irq_a
);
  logic [tcc_pkg::CTRL_W-1:0] ctrl_r;
  logic [CNT_W-1:0] count_value_r;
  logic [CNT_W-1:0] capture_compare_reg_a_r;
  logic [tcc_pkg::ST_W-1:0] status_r;
  logic [tcc_pkg::ST_W-1:0] mask_r;
  logic [tcc_pkg::DATA_W-1:0] rdata_r;
  logic timer_out_r;
  logic match_pulse_r;
  tcc_pkg::tcc_mode_t mode;
  logic running;
  logic cap_mode;
  logic pin_is_out;
  logic edge_a;
  logic edge_b_raw;
  logic edge_b;
  logic read_count;
  logic count_en;
  logic match_a;
  logic wrap;
  logic capture;
  logic clear_cnt;
  logic [tcc_pkg::ST_W-1:0] st_set;
  logic [tcc_pkg::ST_W-1:0] st_clr;

  // ==========================================================
  // control decode
  assign mode = tcc_pkg::tcc_mode_t'(
    ctrl_r[tcc_pkg::CTRL_MODE_LO +: tcc_pkg::CTRL_MODE_W]);
  assign running = ctrl_r[tcc_pkg::CTRL_RUN] &&
                   (mode != tcc_pkg::TCC_STOPPED);
  assign cap_mode = ctrl_r[tcc_pkg::CTRL_CAP_A];
  assign pin_is_out = ctrl_r[tcc_pkg::CTRL_PIN_OUT];

  // ==========================================================
  // pin synchronisers
  tcc_edge_sync u_sync_a (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_pin(i_edge_input_a),
    .i_rise(ctrl_r[tcc_pkg::CTRL_EDGE_A_RISE]),
    .o_edge(edge_a)
  );

  tcc_edge_sync u_sync_b (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_pin(i_shared_port_pin),
    .i_rise(ctrl_r[tcc_pkg::CTRL_EDGE_B_RISE]),
    .o_edge(edge_b_raw)
  );

  // pin input masked in output use
  assign edge_b = edge_b_raw && !pin_is_out;

  // ==========================================================
  // count control
  // freeze during count read
  assign read_count = i_rd && (i_addr == tcc_pkg::OFF_COUNT);
  assign count_en = running && !read_count;

  // zero compare fires on 0 to 1
  assign match_a = count_en && !cap_mode &&
    ((capture_compare_reg_a_r == tcc_pkg::CNT_RST) ?
     (count_value_r == tcc_pkg::CNT_RST) :
     (count_value_r + CNT_W'(1) == capture_compare_reg_a_r));
  assign wrap = count_en && (count_value_r == tcc_pkg::CNT_MAX);

  // clear sources for the clear-and-start modes
  assign clear_cnt =
    ((mode == tcc_pkg::TCC_CLR_MATCH) && match_a &&
     (capture_compare_reg_a_r != tcc_pkg::CNT_RST)) ||
    ((mode == tcc_pkg::TCC_CLR_EDGE_A) && edge_a && running);

  // stopped timer takes no defined capture
  assign capture = cap_mode && edge_b && running;

  // ==========================================================
  // counter
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      count_value_r <= tcc_pkg::CNT_RST;
    end else if (!running) begin
      count_value_r <= tcc_pkg::CNT_RST;
    end else if (clear_cnt) begin
      count_value_r <= tcc_pkg::CNT_RST;
    end else if (count_en) begin
      // wraps from max to zero naturally
      count_value_r <= count_value_r + CNT_W'(1);
    end
  end

  // ==========================================================
  // capture/compare register a
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      capture_compare_reg_a_r <= tcc_pkg::CCA_RST;
    end else if (capture) begin
      capture_compare_reg_a_r <= count_value_r;
    end else if (i_wr && i_addr == tcc_pkg::OFF_CCA) begin
      capture_compare_reg_a_r <= i_wdata[CNT_W-1:0];
    end
  end

  // ==========================================================
  // control and mask registers
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      ctrl_r <= tcc_pkg::CTRL_RST;
    end else if (i_wr && i_addr == tcc_pkg::OFF_CTRL) begin
      ctrl_r <= i_wdata[tcc_pkg::CTRL_W-1:0];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      mask_r <= tcc_pkg::ST_RST;
    end else if (i_wr && i_addr == tcc_pkg::OFF_MASK) begin
      mask_r <= i_wdata[tcc_pkg::ST_W-1:0];
    end
  end

  // ==========================================================
  // sticky status, set wins over write-one-clear
  always_comb begin
    st_set = tcc_pkg::ST_RST;
    st_set[tcc_pkg::ST_MATCH_A] = match_a;
    st_set[tcc_pkg::ST_OVF] = wrap;
    st_set[tcc_pkg::ST_CAP_A] = capture;
    st_clr = (i_wr && i_addr == tcc_pkg::OFF_STATUS) ?
             i_wdata[tcc_pkg::ST_W-1:0] : tcc_pkg::ST_RST;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      status_r <= tcc_pkg::ST_RST;
    end else begin
      status_r <= (status_r & ~st_clr) | st_set;
    end
  end

  assign o_irq = |(status_r & mask_r);

  // match pulse output, one cycle
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      match_pulse_r <= 1'b0;
    end else begin
      match_pulse_r <= match_a;
    end
  end

  assign o_match_irq_a = match_pulse_r;

  // ==========================================================
  // timer output toggles on match
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      timer_out_r <= 1'b0;
    end else if (!running) begin
      timer_out_r <= 1'b0;
    end else if (match_a) begin
      timer_out_r <= !timer_out_r;
    end
  end

  // drive pin only in output use
  assign o_shared_port_pin = timer_out_r && pin_is_out;
  assign o_shared_port_pin_oe = pin_is_out;

  // ==========================================================
  // read data, one cycle after strobe
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      rdata_r <= '0;
    end else if (i_rd) begin
      unique case (i_addr)
        tcc_pkg::OFF_CTRL:
          rdata_r <= tcc_pkg::DATA_W'(ctrl_r);
        tcc_pkg::OFF_COUNT:
          rdata_r <= tcc_pkg::DATA_W'(count_value_r);
        tcc_pkg::OFF_CCA:
          rdata_r <= tcc_pkg::DATA_W'(capture_compare_reg_a_r);
        tcc_pkg::OFF_STATUS:
          rdata_r <= tcc_pkg::DATA_W'(status_r);
        tcc_pkg::OFF_MASK:
          rdata_r <= tcc_pkg::DATA_W'(mask_r);
        default:
          rdata_r <= '0;
      endcase
    end else begin
      rdata_r <= '0;
    end
  end

  assign o_rdata = rdata_r;
endmodule : tcc_timer_a

/* File: verif/tcc_timer_a_properties.sv */
/* port checker for tcc_timer_a.
   assumes the top module's port names; bound below. */
`timescale 1ns/1ps
module tcc_timer_a_properties (
  // clock, reset and bus
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  // pin and interrupt
  input wire logic o_shared_port_pin,
  input wire logic o_shared_port_pin_oe,
  input wire logic o_irq
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  // ==========================================================
  // assertions
  a_read_freeze: assert property (
    $past(i_rd, 2) && $past(i_rd) && $past(i_addr, 2) == 4'h1
    && $past(i_addr) == 4'h1 |-> o_rdata == $past(o_rdata))
    else $error("count moved during read");
  a_rdata_quiet: assert property (
    !$past(i_rd) |-> o_rdata == 16'h0000) else $error("stray data");
  a_pin_released: assert property (
    !o_shared_port_pin_oe |-> !o_shared_port_pin) else $error("pin on");
  a_oe_follows_ctrl: assert property (
    i_wr && i_addr == 4'h0 |=> o_shared_port_pin_oe == $past(i_wdata[4]))
    else $error("enable wrong");
  a_irq_masked_off: assert property (
    i_wr && i_addr == 4'h4 && i_wdata[2:0] == 3'h0 |=> !o_irq)
    else $error("masked irq");
  a_ctrl_narrow: assert property (
    i_rd && i_addr == 4'h0 |=> o_rdata[15:7] == 9'h000)
    else $error("ctrl wide");
  a_unmapped_zero: assert property (
    i_rd && i_addr > 4'h4 |=> o_rdata == 16'h0000) else $error("unmapped");
  a_stop_clears: assert property (
    i_wr && i_addr == 4'h0 && !i_wdata[0] ##1 !i_wr ##1 i_rd
    && i_addr == 4'h1 |=> o_rdata == 16'h0000) else $error("stop count");
endmodule : tcc_timer_a_properties
bind tcc_timer_a tcc_timer_a_properties i_props (.i_core_clk, .i_rstn,
  .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_shared_port_pin,
  .o_shared_port_pin_oe, .o_irq);

/* File: verif/tcc_pin_drv.sv */
/* pin side model: a ten-cycle high pulse per request.
   assumes requests arrive on the core clock. */
`timescale 1ns/1ps
module tcc_pin_drv (
  // clock and request
  input wire logic i_core_clk,
  input wire logic i_go,
  // pin
  output logic o_pin
);
  logic [3:0] cnt_r = 4'h0;
  // ==========================================================
  // pulse long enough for the synchroniser
  always_ff @(posedge i_core_clk) begin
    if (i_go)
      cnt_r <= 4'hA;
    else if (cnt_r != 4'h0)
      cnt_r <= cnt_r - 4'h1;
  end
  assign o_pin = (cnt_r != 4'h0);
endmodule : tcc_pin_drv

/* File: verif/tcc_timer_a_test.sv */
/* self-checking bench for tcc_timer_a.
   assumes tcc_pin_drv and the bound port checker. */
`timescale 1ns/1ps
module tcc_timer_a_test;
  logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, go = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata, d0, d1;
  logic pin_o, pin_oe, irq, mirq, drv_pin, pin_w;
  int fail_count = 0, checks_done = 0, cyc = 0, n;
  // ==========================================================
  // clock, pin wire and hang guard
  always #12.5 clk = ~clk;
  assign pin_w = pin_oe ? pin_o : drv_pin;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      fail_count = fail_count + 1;
      end_sim();
    end
  end
  tcc_pin_drv i_pin (.i_core_clk(clk), .i_go(go), .o_pin(drv_pin));
  tcc_timer_a i_dut (.i_core_clk(clk), .i_rstn(rstn), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_edge_input_a(1'b0), .i_shared_port_pin(pin_w),
    .o_shared_port_pin(pin_o), .o_shared_port_pin_oe(pin_oe),
    .o_irq(irq), .o_match_irq_a(mirq));
  // ==========================================================
  // tasks
  task automatic chk(input logic [15:0] s, input logic [15:0] e,
                     input string nm);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg
  task automatic irq_is(input logic e);
    @(posedge clk);
    #1 chk({15'h0000, irq}, {15'h0000, e}, "irq");
  endtask : irq_is
  task automatic end_sim();
    if (fail_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim
  // ==========================================================
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    wr_reg(4'h2, 16'h8000);
    wr_reg(4'h0, 16'h0001);
    // back-to-back count reads
    @(posedge clk);
    rd <= 1'b1;
    addr <= 4'h1;
    @(posedge clk);
    #1 d0 = rdata;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, d0, "count");
    wr_reg(4'h2, 16'h0000);
    wr_reg(4'h3, 16'h0007);
    wr_reg(4'h4, 16'h0007);
    n = 0;
    while (mirq !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    chk(16'(n > 65000), 16'h0001, "wrap");
    rd_reg(4'h3, d0);
    chk(d0, 16'h0003, "status");
    irq_is(1'b1);
    wr_reg(4'h4, 16'h0000);
    irq_is(1'b0);
    wr_reg(4'h4, 16'h0007);
    irq_is(1'b1);
    wr_reg(4'h3, 16'h0003);
    irq_is(1'b0);
    wr_reg(4'h0, 16'h0000);
    rd_reg(4'h1, d0);
    chk(d0, 16'h0000, "stopped");
    wr_reg(4'h0, 16'h0049);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    while (irq !== 1'b1)
      @(posedge clk);
    rd_reg(4'h2, d0);
    rd_reg(4'h1, d1);
    chk(16'(d1 - d0 < 16'h0010), 16'h0001, "capture");
    rd_reg(4'h3, d0);
    chk(d0, 16'h0004, "cap flag");
    wr_reg(4'h3, 16'h0007);
    wr_reg(4'h0, 16'h0041);
    wr_reg(4'h2, 16'h1234);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (20) @(posedge clk);
    rd_reg(4'h2, d0);
    chk(d0, 16'h1234, "compare");
    wr_reg(4'h0, 16'h0059);
    #1 chk({15'h0000, pin_oe}, 16'h0001, "oe");
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (20) @(posedge clk);
    rd_reg(4'h3, d0);
    chk(d0, 16'h0000, "pin out");
    wr_reg(4'h0, 16'h0000);
    wr_reg(4'h3, 16'h0007);
    wr_reg(4'h2, 16'h0010);
    wr_reg(4'h0, 16'h0011);
    repeat (30) @(posedge clk);
    #1 chk({15'h0000, pin_o}, 16'h0001, "timer out");
    rd_reg(4'h3, d0);
    chk(d0, 16'h0001, "match flag");
    wr_reg(4'h0, 16'h0000);
    wr_reg(4'h0, 16'h0013);
    repeat (40) @(posedge clk);
    rd_reg(4'h1, d0);
    chk(16'(d0 < 16'h0010), 16'h0001, "clear match");
    rd_reg(4'h7, d0);
    chk(d0, 16'h0000, "unmapped");
    end_sim();
  end
endmodule : tcc_timer_a_test
